// ---- common/bulk_fault_pkg.sv ----
// Notes on behaviour
// - A query addressed to this channel returns all fault status in one response.
// - Faults are packed into bit positions of the returned characters.
// - A fault flag reads 1 while its fault is present, 0 otherwise.
// - Bit 6 of every status character is always 1, keeping it printable.
// - First modulator character bit 5 reports a modulator module fault.
// - First modulator character bit 4 shows the actual RF output state.
// - First modulator character bits 3..0 count stored modulator faults, 0 to 10.
// - Burst mode: second modulator character flags IF synth, clock synth, gain level.
// - Continuous mode adds I channel on bit 3 and Q channel on bit 2.
// - Third modulator character carries no fault flags.
// - First demodulator character bit 5 reports a demodulator module fault.
// - First demodulator character bit 4 is carrier detect, 0 when decoder locked.
// - First demodulator character bits 3..0 count stored demodulator faults, 0 to 10.
// - Second demodulator character flags IF synth lock loss and I channel fault.
// - Second demodulator character bit 2 flags a descrambler fault.
// - Second demodulator character bit 1 flags error rate threshold exceeded.
// - Transmit mode code 1 selects burst, code 2 continuous layout.
package bulk_fault_pkg;

   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_CHAN      = 8'h04;
   localparam logic [7:0]  ADDR_STAT      = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
   localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
   localparam logic [7:0]  ADDR_SNAP      = 8'h14;

   localparam logic [1:0]  TXM_BURST      = 2'h1;
   localparam logic [1:0]  TXM_CONT       = 2'h2;
   localparam logic [1:0]  RESET_TXM      = TXM_BURST;
   localparam logic [11:0] RESET_CHAN     = 12'h001;
   localparam logic [3:0]  COUNT_MAX      = 4'hA;

   localparam logic [3:0]  CMD_CR_IDX     = 4'hC;
   localparam logic [3:0]  RSP_LAST_IDX   = 4'hF;

   localparam logic [7:0]  CH_SPACE       = 8'h20;
   localparam logic [7:0]  CH_CR          = 8'h0D;
   localparam logic [7:0]  CH_LF          = 8'h0A;
   localparam logic [7:0]  CH_DIGIT       = 8'h30;
   localparam logic [7:0]  CH_M           = 8'h4D;
   localparam logic [7:0]  CH_C           = 8'h43;
   localparam logic [7:0]  CH_B           = 8'h42;
   localparam logic [7:0]  CH_S           = 8'h53;
   localparam logic [7:0]  CH_F           = 8'h46;
   localparam logic [7:0]  CH_UNDER       = 8'h5F;

   localparam int          IRQ_SERVED     = 0;
   localparam int          IRQ_BAD_CMD    = 1;
   localparam int          IRQ_DROPPED    = 2;
   localparam int          IRQ_W          = 3;

   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;

   typedef struct packed {
      logic       mod_module;
      logic       rf_on;
      logic [3:0] mod_count;
      logic       mod_if_synth;
      logic       mod_clk_synth;
      logic       mod_i_chan;
      logic       mod_q_chan;
      logic       gain_control_level;
      logic       dem_module;
      logic       dem_decoder_lock;
      logic [3:0] dem_count;
      logic       dem_if_lock_lost;
      logic       dem_i_chan;
      logic       descrambler;
      logic       bit_error_rate;
   } fault_in_t;

   typedef struct packed {
      logic [6:0] a;
      logic [6:0] b;
      logic [6:0] c;
      logic [6:0] d;
      logic [6:0] e;
   } status_chars_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } resp_state_t;

endpackage

// ---- hdl/bulk_fault_status_encoder.sv ----
`timescale 1ns/1ps
module bulk_fault_status_encoder
   import bulk_fault_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_b,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire fault_in_t   i_faults,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   output logic             o_tx_valid,
   output logic      [7:0]  o_tx_data,
   input  wire logic        i_tx_ready,
   output logic             o_irq
);

   logic [1:0]        transmit_mode_select;
   logic [11:0]       chan;
   logic [IRQ_W-1:0]  irq_stat;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_set;
   logic              wr_pend;
   logic              rd_pend;
   logic [7:0]        bus_addr;
   logic              wr_en;
   logic [3:0]        rx_idx;
   logic              rx_bad;
   logic              query_hit;
   logic              bad_cmd;
   resp_state_t       state;
   logic [3:0]        tx_idx;
   status_chars_t     snap;
   logic [11:0]       snap_chan;
   status_chars_t     next_chars;
   logic              tx_accept;
   logic              resp_done;

   // Counts above the documented range are clamped so the low nibble never lies.
   function automatic logic [3:0] clamp_count(input logic [3:0] n);
      clamp_count = (n > COUNT_MAX) ? COUNT_MAX : n;
   endfunction

   function automatic logic [7:0] digit_char(input logic [3:0] n);
      digit_char = CH_DIGIT | {4'h0, n};
   endfunction

   // Expected query bytes: three channel digits, space, M C, space, query word, CR.
   function automatic logic [7:0] cmd_byte(input logic [3:0] idx, input logic [11:0] ch);
      case (idx)
         4'h0:    cmd_byte = digit_char(ch[11:8]);
         4'h1:    cmd_byte = digit_char(ch[7:4]);
         4'h2:    cmd_byte = digit_char(ch[3:0]);
         4'h3:    cmd_byte = CH_SPACE;
         4'h4:    cmd_byte = CH_M;
         4'h5:    cmd_byte = CH_C;
         4'h6:    cmd_byte = CH_SPACE;
         4'h7:    cmd_byte = CH_B;
         4'h8:    cmd_byte = CH_C;
         4'h9:    cmd_byte = CH_S;
         4'hA:    cmd_byte = CH_F;
         4'hB:    cmd_byte = CH_UNDER;
         default: cmd_byte = CH_CR;
      endcase
   endfunction

   function automatic logic [7:0] resp_byte(input logic [3:0] idx, input status_chars_t sc,
                                            input logic [11:0] ch);
      case (idx)
         4'h0:    resp_byte = digit_char(ch[11:8]);
         4'h1:    resp_byte = digit_char(ch[7:4]);
         4'h2:    resp_byte = digit_char(ch[3:0]);
         4'h3:    resp_byte = CH_SPACE;
         4'h4:    resp_byte = CH_B;
         4'h5:    resp_byte = CH_C;
         4'h6:    resp_byte = CH_S;
         4'h7:    resp_byte = CH_F;
         4'h8:    resp_byte = CH_UNDER;
         4'h9:    resp_byte = {1'b0, sc.a};
         4'hA:    resp_byte = {1'b0, sc.b};
         4'hB:    resp_byte = {1'b0, sc.c};
         4'hC:    resp_byte = {1'b0, sc.d};
         4'hD:    resp_byte = {1'b0, sc.e};
         4'hE:    resp_byte = CH_CR;
         default: resp_byte = CH_LF;
      endcase
   endfunction

   function automatic logic [7:0] resp_byte_at(input logic [3:0] idx, input status_chars_t sc,
                                               input logic [11:0] ch);
      // The closing CR and LF always take the last two indices, after character e.
      if (idx == RSP_LAST_IDX - 4'h1)
         resp_byte_at = CH_CR;
      else if (idx == RSP_LAST_IDX)
         resp_byte_at = CH_LF;
      else
         resp_byte_at = resp_byte(idx, sc, ch);
   endfunction

   always_comb
   begin
      next_chars = '0;
      next_chars.a[6] = 1'b1;
      next_chars.b[6] = 1'b1;
      next_chars.c[6] = 1'b1;
      next_chars.d[6] = 1'b1;
      next_chars.e[6] = 1'b1;
      next_chars.a[5] = i_faults.mod_module;
      next_chars.a[4] = i_faults.rf_on;
      next_chars.a[3:0] = clamp_count(i_faults.mod_count);
      next_chars.b[5] = i_faults.mod_if_synth;
      next_chars.b[4] = i_faults.mod_clk_synth;
      next_chars.b[1] = i_faults.gain_control_level;
      if (transmit_mode_select == TXM_CONT)
      begin
         next_chars.b[3] = i_faults.mod_i_chan;
         next_chars.b[2] = i_faults.mod_q_chan;
      end
      next_chars.c[5:0] = 6'h00;
      next_chars.d[5] = i_faults.dem_module;
      next_chars.d[4] = ~i_faults.dem_decoder_lock;
      next_chars.d[3:0] = clamp_count(i_faults.dem_count);
      next_chars.e[5] = i_faults.dem_if_lock_lost;
      next_chars.e[4] = i_faults.dem_i_chan;
      next_chars.e[2] = i_faults.descrambler;
      next_chars.e[1] = i_faults.bit_error_rate;
   end

   assign wr_en     = wr_pend;
   assign tx_accept = o_tx_valid & i_tx_ready;
   assign resp_done = (state == ST_SEND) & tx_accept & (tx_idx == RSP_LAST_IDX);

   // Address phase capture; only whole-word writes act on the registers, reads of any size are answered.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wr_pend  <= 1'b0;
         rd_pend  <= 1'b0;
         bus_addr <= 8'h00;
      end
      else if (i_hready)
      begin
         wr_pend  <= i_hsel & i_htrans[1] & i_hwrite & (i_hsize == HSIZE_WORD);
         rd_pend  <= i_hsel & i_htrans[1] & ~i_hwrite;
         bus_addr <= i_haddr[7:0];
      end
      else
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
      end
   end

   // Reads take one wait state so a read right after a write sees the new value.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h0000_0000;
         o_hresp     <= 1'b0;
      end
      else
      begin
         o_hresp <= 1'b0;
         if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
         begin
            o_hreadyout <= 1'b0;
         end
         else if (rd_pend)
         begin
            o_hreadyout <= 1'b1;
            case (bus_addr)
               ADDR_CTRL:     o_hrdata <= {30'h0, transmit_mode_select};
               ADDR_CHAN:     o_hrdata <= {20'h0, chan};
               ADDR_STAT:     o_hrdata <= {27'h0, rx_bad, tx_idx[3:0] == 4'h0 ? 1'b0 : 1'b1,
                                           state == ST_SEND, o_tx_valid, query_hit};
               ADDR_IRQ_STAT: o_hrdata <= {29'h0, irq_stat};
               ADDR_IRQ_MASK: o_hrdata <= {29'h0, irq_mask};
               ADDR_SNAP:     o_hrdata <= {4'h0, snap.a, snap.b, snap.d, snap.e};
               default:       o_hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // only codes 1 and 2 are accepted
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         transmit_mode_select <= RESET_TXM;
      else if (wr_en && bus_addr == ADDR_CTRL &&
               (i_hwdata[1:0] == TXM_BURST || i_hwdata[1:0] == TXM_CONT))
         transmit_mode_select <= i_hwdata[1:0];
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         chan <= RESET_CHAN;
      else if (wr_en && bus_addr == ADDR_CHAN)
         chan <= i_hwdata[11:0];
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         irq_mask <= '0;
      else if (wr_en && bus_addr == ADDR_IRQ_MASK)
         irq_mask <= i_hwdata[IRQ_W-1:0];
   end

   always_comb
   begin
      irq_set              = '0;
      irq_set[IRQ_SERVED]  = resp_done;
      irq_set[IRQ_BAD_CMD] = bad_cmd;
      irq_set[IRQ_DROPPED] = query_hit & (state == ST_SEND);
   end

   // A new event in the cycle of its clear wins, so no event is lost.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         irq_stat <= '0;
      else if (wr_en && bus_addr == ADDR_IRQ_STAT)
         irq_stat <= (irq_stat & ~i_hwdata[IRQ_W-1:0]) | irq_set;
      else
         irq_stat <= irq_stat | irq_set;
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_irq <= 1'b0;
      else
         o_irq <= |((irq_stat | irq_set) & irq_mask);
   end

   // match a query to this channel
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rx_idx    <= 4'h0;
         rx_bad    <= 1'b0;
         query_hit <= 1'b0;
         bad_cmd   <= 1'b0;
      end
      else
      begin
         query_hit <= 1'b0;
         bad_cmd   <= 1'b0;
         if (i_rx_valid)
         begin
            if (i_rx_data == CH_CR)
            begin
               rx_idx    <= 4'h0;
               rx_bad    <= 1'b0;
               query_hit <= ~rx_bad & (rx_idx == CMD_CR_IDX);
               bad_cmd   <= (rx_bad | (rx_idx != CMD_CR_IDX)) & (rx_idx != 4'h0);
            end
            else
            begin
               if (rx_idx >= CMD_CR_IDX || i_rx_data != cmd_byte(rx_idx, chan))
                  rx_bad <= 1'b1;
               if (rx_idx != 4'hF)
                  rx_idx <= rx_idx + 4'h1;
            end
         end
      end
   end

   // snapshot taken once so the reply is self-consistent
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         snap      <= '0;
         snap_chan <= RESET_CHAN;
      end
      else if (query_hit && state == ST_IDLE)
      begin
         snap      <= next_chars;
         snap_chan <= chan;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state      <= ST_IDLE;
         tx_idx     <= 4'h0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (query_hit)
               begin
                  state      <= ST_SEND;
                  tx_idx     <= 4'h0;
                  o_tx_valid <= 1'b1;
                  o_tx_data  <= resp_byte_at(4'h0, next_chars, chan);
               end
            end
            ST_SEND:
            begin
               if (tx_accept)
               begin
                  if (tx_idx == RSP_LAST_IDX)
                  begin
                     state      <= ST_IDLE;
                     tx_idx     <= 4'h0;
                     o_tx_valid <= 1'b0;
                  end
                  else
                  begin
                     tx_idx    <= tx_idx + 4'h1;
                     o_tx_data <= resp_byte_at(tx_idx + 4'h1, snap, snap_chan);
                  end
               end
            end
            default:
            begin
               state      <= ST_IDLE;
               o_tx_valid <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- tb/bulk_fault_props.sv ----
`timescale 1ns/1ps
module bulk_fault_props
   import bulk_fault_pkg::*;
(
   input wire logic       i_mclk,
   input wire logic       i_rst_b,
   input wire logic       o_hreadyout,
   input wire logic       o_hresp,
   input wire logic       o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic       i_tx_ready
);
   logic [3:0] idx;
   wire        sent = o_tx_valid && i_tx_ready;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // Position of the offered byte within the sixteen-byte response.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         idx <= 4'h0;
      else if (sent)
         idx <= idx + 4'h1;
   end
   property p_printable; o_tx_valid && idx >= 4'h9 && idx <= 4'hD |-> o_tx_data[7:6] == 2'h1; endproperty
   a_printable: assert property (p_printable) else $error("status char not printable");
   property p_mod_count; o_tx_valid && idx == 4'h9 |-> o_tx_data[3:0] <= COUNT_MAX; endproperty
   a_mod_count: assert property (p_mod_count) else $error("mod count out of range");
   property p_dem_count; o_tx_valid && idx == 4'hC |-> o_tx_data[3:0] <= COUNT_MAX; endproperty
   a_dem_count: assert property (p_dem_count) else $error("demod count out of range");
   property p_third; o_tx_valid && idx == 4'hB |-> o_tx_data == 8'h40; endproperty
   a_third: assert property (p_third) else $error("third char not empty");
   property p_reserved; o_tx_valid && idx == 4'hD |-> !o_tx_data[3] && !o_tx_data[0]; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   property p_header; o_tx_valid && idx == 4'h4 |-> o_tx_data == CH_B; endproperty
   a_header: assert property (p_header) else $error("header out of place");
   property p_cr; o_tx_valid && idx == 4'hE |-> o_tx_data == CH_CR; endproperty
   a_cr: assert property (p_cr) else $error("carriage return missing");
   property p_lf; sent && idx == 4'hE |=> o_tx_valid && o_tx_data == CH_LF; endproperty
   a_lf: assert property (p_lf) else $error("line feed missing");
   property p_hold; o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data); endproperty
   a_hold: assert property (p_hold) else $error("byte dropped while stalled");
   property p_wait; !o_hreadyout |=> o_hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("read wait too long");
   property p_okay; o_hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus error response");
   c_end: cover property (sent && idx == 4'hF);
   c_stall: cover property (o_tx_valid && !i_tx_ready);
   c_read: cover property (!o_hreadyout);
endmodule

// ---- tb/control_host.sv ----
`timescale 1ns/1ps
module control_host
(
   input  wire logic       i_mclk,
   input  wire logic       i_slow,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready,
   output logic            o_rx_valid,
   output logic      [7:0] o_rx_data
);
   logic [7:0] got[$];
   initial
   begin
      o_tx_ready = 1'b1;
      o_rx_valid = 1'b0;
      o_rx_data  = 8'h00;
   end
   // A slow host accepts every other cycle, so each byte must wait on the sink.
   always @(posedge i_mclk)
   begin
      if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1)
         got.push_back(i_tx_data);
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
   end
   // Bytes go out back to back; an idle data line shows the inverse of the last byte.
   task send_line(input logic [7:0] line[13]);
      foreach (line[k])
      begin
         o_rx_valid <= 1'b1;
         o_rx_data  <= line[k];
         @(posedge i_mclk);
      end
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~line[12];
   endtask
endmodule

// ---- tb/bulk_fault_status_encoder_bench.sv ----
`timescale 1ns/1ps
module bulk_fault_status_encoder_bench
   import bulk_fault_pkg::*;
   ;
   logic        mclk;
   logic        rst_b;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   fault_in_t   faults;
   fault_in_t   f;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_ready;
   logic        irq;
   logic        slow;
   logic [1:0]  mode;
   logic [31:0] word;
   logic [7:0]  exp_q[$];
   int          n_fail;
   int          check_count;

   bulk_fault_status_encoder bulk_fault_status_encoder_i (.i_mclk(mclk), .i_rst_b(rst_b), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_faults(faults),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
      .i_tx_ready(tx_ready), .o_irq(irq));
   control_host control_host_i (.i_mclk(mclk), .i_slow(slow), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
      .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   task chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask

   // Read data and ready are taken as they stood before the sampling edge.
   task ahb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task expect_resp(input logic [1:0] m, input fault_in_t x);
      logic       c;
      logic [3:0] mc;
      logic [3:0] dc;
      c  = (m == TXM_CONT);
      // Counts beyond the documented range read as the top of the range.
      mc = (x.mod_count > COUNT_MAX) ? COUNT_MAX : x.mod_count;
      dc = (x.dem_count > COUNT_MAX) ? COUNT_MAX : x.dem_count;
      exp_q = '{CH_DIGIT, CH_DIGIT, CH_DIGIT + 8'h1, CH_SPACE, CH_B, CH_C, CH_S, CH_F, CH_UNDER};
      exp_q.push_back({2'h1, x.mod_module, x.rf_on, mc});
      exp_q.push_back({2'h1, x.mod_if_synth, x.mod_clk_synth, c & x.mod_i_chan, c & x.mod_q_chan,
                       x.gain_control_level, 1'b0});
      exp_q.push_back(8'h40);
      exp_q.push_back({2'h1, x.dem_module, ~x.dem_decoder_lock, dc});
      exp_q.push_back({2'h1, x.dem_if_lock_lost, x.dem_i_chan, 1'b0, x.descrambler, x.bit_error_rate, 1'b0});
      exp_q.push_back(CH_CR);
      exp_q.push_back(CH_LF);
   endtask

   task query(input logic [7:0] last);
      logic [7:0] line[13];
      line = '{CH_DIGIT, CH_DIGIT, last, CH_SPACE, CH_M, CH_C, CH_SPACE, CH_B, CH_C, CH_S, CH_F, CH_UNDER, CH_CR};
      control_host_i.got.delete();
      control_host_i.send_line(line);
      for (int k = 0; k < 120 && control_host_i.got.size() < 16; k++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask

   initial
   begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      faults = '0;
      slow = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      ahb(ADDR_CTRL, 1'b0, 32'h0, word);
      chk32(word, {30'h0, RESET_TXM});
      ahb(ADDR_CHAN, 1'b0, 32'h0, word);
      chk32(word, {20'h0, RESET_CHAN});
      ahb(8'h18, 1'b0, 32'h0, word);
      chk32(word, 32'h0);
      ahb(ADDR_IRQ_MASK, 1'b1, 32'h1, word);
      for (int p = 0; p < 4; p++)
      begin
         mode = p[0] ? TXM_CONT : TXM_BURST;
         f = p[1] ? '1 : '0;
         f.mod_count = p[1] ? 4'hF : 4'h3;
         f.dem_count = p[1] ? 4'h3 : 4'hB;
         faults <= f;
         slow <= p[0] ^ p[1];
         ahb(ADDR_CTRL, 1'b1, {30'h0, mode}, word);
         // A code that names no mode must leave the layout alone.
         ahb(ADDR_CTRL, 1'b1, 32'h3, word);
         ahb(ADDR_CTRL, 1'b0, 32'h0, word);
         chk32(word, {30'h0, mode});
         expect_resp(mode, f);
         query(CH_DIGIT + 8'h1);
         chk32(control_host_i.got.size(), 32'd16);
         foreach (exp_q[k])
            chk8(control_host_i.got[k], exp_q[k]);
         ahb(ADDR_SNAP, 1'b0, 32'h0, word);
         chk32(word, {4'h0, exp_q[9][6:0], exp_q[10][6:0], exp_q[12][6:0], exp_q[13][6:0]});
         chk32({31'h0, irq}, 32'h1);
         ahb(ADDR_IRQ_STAT, 1'b0, 32'h0, word);
         chk32(word, 32'h1);
         ahb(ADDR_IRQ_STAT, 1'b1, 32'h1, word);
         ahb(ADDR_IRQ_STAT, 1'b0, 32'h0, word);
         chk32(word, 32'h0);
         chk32({31'h0, irq}, 32'h0);
         $display("test %0d done", p);
      end
      // Another channel's query is silent; its event is masked off the interrupt.
      query(CH_DIGIT + 8'h2);
      chk32(control_host_i.got.size(), 32'd0);
      ahb(ADDR_IRQ_STAT, 1'b0, 32'h0, word);
      chk32(word, 32'h2);
      chk32({31'h0, irq}, 32'h0);
      $display("test 4 done");
      conclude();
   end

   initial
   begin
      #100000;
      n_fail++;
      conclude();
   end
endmodule

bind bulk_fault_status_encoder bulk_fault_props bulk_fault_props_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
   .i_tx_ready(i_tx_ready));
